//--- logic/scer_recorder.sv
/*
  synchronism-check event recorder: three stages of status bits become
  masked, time-stamped on/off events, one per cycle, and a record log.
  assumes all status and measurement inputs come from logic on REF_CLK.
*/
// Functional notes
// - each change of a monitored status bit makes an on or off event
// - per-event masks choose whether on, off, or both events are stored
// - every event carries the millisecond stamp taken when the change was seen
// - three independent stages, each with its own inputs and event codes
// - stage status bits are registered outputs for io and user logic
// - per stage: blocked, check ok, bypass, voltage condition match events
// - per stage: summary events for voltage, angle and frequency difference ok
// - separate detailed events for voltage, angle and frequency difference ok
// - voltage too high direction: bus above line and line above bus events
// - frequency too high direction: bus above line and line above bus events
// - angle too high direction: bus leads and line leads events
// - events for the four combined live/dead states of bus and line
// - events for bus live, bus dead, line live and line dead
// - keep the latest twelve records with millisecond stamp and event identity
// - records hold references, conditions, differences, limit states and setting group
// - voltage condition setting picks allowed live/dead states or bypass, default live-live
// - angle is within limit only below a 3 to 90 degree maximum
`timescale 1ns/1ps
module scer_recorder
  import scer_pkg::*;
#(
  parameter int CYC_MS = scer_pkg::CYC_PER_MS
) (
  // clock and reset
  input  wire logic                                      REF_CLK,
  input  wire logic                                      RST_N,
  // decision status, one bit per stage
  input  wire logic [scer_pkg::NUM_STAGES-1:0]           BLOCKED,
  input  wire logic [scer_pkg::NUM_STAGES-1:0]           CHECK_OK,
  input  wire logic [scer_pkg::NUM_STAGES-1:0]           BYPASS,
  input  wire logic [scer_pkg::NUM_STAGES-1:0]           VDIFF_OK,
  input  wire logic [scer_pkg::NUM_STAGES-1:0]           FDIFF_OK,
  input  wire logic [scer_pkg::NUM_STAGES-1:0]           VBUS_HIGH,
  input  wire logic [scer_pkg::NUM_STAGES-1:0]           VLINE_HIGH,
  input  wire logic [scer_pkg::NUM_STAGES-1:0]           FBUS_HIGH,
  input  wire logic [scer_pkg::NUM_STAGES-1:0]           FLINE_HIGH,
  input  wire logic [scer_pkg::NUM_STAGES-1:0]           BUS_LEADS,
  input  wire logic [scer_pkg::NUM_STAGES-1:0]           LINE_LEADS,
  input  wire logic [scer_pkg::NUM_STAGES-1:0]           BUS_LIVE,
  input  wire logic [scer_pkg::NUM_STAGES-1:0]           BUS_DEAD,
  input  wire logic [scer_pkg::NUM_STAGES-1:0]           LINE_LIVE,
  input  wire logic [scer_pkg::NUM_STAGES-1:0]           LINE_DEAD,
  // measurements and settings, one slice per stage; setting group shared by all stages
  input  wire logic [scer_pkg::NUM_STAGES*16-1:0]        REF1_VOLT,
  input  wire logic [scer_pkg::NUM_STAGES*16-1:0]        REF2_VOLT,
  input  wire logic [scer_pkg::NUM_STAGES*16-1:0]        VDIFF,
  input  wire logic [scer_pkg::NUM_STAGES*16-1:0]        ANGLE_DIFF,
  input  wire logic [scer_pkg::NUM_STAGES*16-1:0]        FDIFF,
  input  wire logic [scer_pkg::NUM_STAGES*16-1:0]        ANGLE_LIMIT,
  input  wire logic [scer_pkg::NUM_STAGES*4-1:0]         U_COND,
  input  wire logic [scer_pkg::GROUP_W-1:0]              SETTING_GROUP,
  // store masks, bit index stage*24 + signal
  input  wire logic [scer_pkg::NUM_SRC-1:0]              STORE_ON_MASK,
  input  wire logic [scer_pkg::NUM_SRC-1:0]              STORE_OFF_MASK,
  // stage status for io and user logic
  output logic      [scer_pkg::NUM_SRC-1:0]              STAT_OUT,
  // event stream to the main event buffer
  output logic                                           EVT_VALID,
  output logic      [scer_pkg::STAGE_W-1:0]              EVT_STAGE,
  output logic      [scer_pkg::CODE_W-1:0]               EVT_CODE,
  output logic                                           EVT_ON,
  output logic      [scer_pkg::TS_W-1:0]                 EVT_TIME,
  // record log read
  input  wire logic [scer_pkg::LOG_IDX_W-1:0]            REC_SEL,
  output logic                                           REC_VALID,
  output logic      [scer_pkg::TS_W-1:0]                 REC_TIME,
  output logic      [scer_pkg::STAGE_W-1:0]              REC_STAGE,
  output logic      [scer_pkg::CODE_W-1:0]               REC_CODE,
  output logic                                           REC_ON,
  output logic      [scer_pkg::MEAS_W-1:0]               REC_REF1,
  output logic      [scer_pkg::MEAS_W-1:0]               REC_REF2,
  output logic      [scer_pkg::UCOND_W-1:0]              REC_UCOND,
  output logic      [scer_pkg::CMB_W-1:0]                REC_VSTATUS,
  output logic      [scer_pkg::MEAS_W-1:0]               REC_VDIFF,
  output logic                                           REC_VDIFF_OK,
  output logic      [scer_pkg::MEAS_W-1:0]               REC_ADIFF,
  output logic                                           REC_ADIFF_OK,
  output logic      [scer_pkg::MEAS_W-1:0]               REC_FDIFF,
  output logic                                           REC_FDIFF_OK,
  output logic      [scer_pkg::GROUP_W-1:0]              REC_GROUP
);
  import scer_pkg::*;

  localparam int PRE_W = $clog2(CYC_MS + 1);

  logic [NUM_SRC-1:0]        cur;
  logic [NUM_SRC-1:0]        stat_ff;
  logic [NUM_SRC-1:0]        pend_ff;
  logic [NUM_SRC-1:0]        pol_ff;
  logic [TS_W-1:0]           ts_ff [NUM_SRC];
  logic [PRE_W-1:0]          pre_ff;
  logic [TS_W-1:0]           time_ms_ff;
  logic                      evt_valid_ff;
  logic [STAGE_W-1:0]        evt_stage_ff;
  logic [CODE_W-1:0]         evt_code_ff;
  logic                      evt_on_ff;
  logic [TS_W-1:0]           evt_time_ff;
  logic [NUM_SRC-1:0]        change;
  logic [NUM_SRC-1:0]        capture;
  logic [NUM_SRC-1:0]        grant;
  logic [NUM_SRC-1:0]        nxt_pend;
  logic [NUM_SRC-1:0]        nxt_pol;
  logic                      found;
  logic [SRC_W-1:0]          sel;
  logic [STAGE_W-1:0]        sel_stage;
  logic [CODE_W-1:0]         sel_code;
  logic [TS_W-1:0]           sel_ts;
  logic [NUM_STAGES*CMB_W-1:0] cmb;
  logic [NUM_STAGES-1:0]     angle_ok;
  logic [NUM_STAGES-1:0]     vcond_ok;
  logic [REC_W-1:0]          rec_wr;
  logic [REC_W-1:0]          rec_q;
  logic                      pre_wrap;

  // lowest pending index wins; one event leaves per cycle
  function automatic logic [SRC_W-1:0] first_set(input logic [NUM_SRC-1:0] v);
    logic [SRC_W-1:0] r;
    r = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) r = SRC_W'(i);
    end
    return r;
  endfunction : first_set

  genvar s;
  generate
    for (s = 0; s < NUM_STAGES; s++) begin : g_stage
      localparam int B = s * SIG_PER_STAGE;
      logic [MEAS_W-1:0] lim;
      // limit held to its legal span so a bad setting cannot open the window
      assign lim = (ANGLE_LIMIT[s*MEAS_W +: MEAS_W] < ANGLE_MIN_CDEG) ? ANGLE_MIN_CDEG :
                   (ANGLE_LIMIT[s*MEAS_W +: MEAS_W] > ANGLE_MAX_CDEG) ? ANGLE_MAX_CDEG :
                   ANGLE_LIMIT[s*MEAS_W +: MEAS_W];
      assign angle_ok[s] = ANGLE_DIFF[s*MEAS_W +: MEAS_W] < lim;
      assign cmb[s*CMB_W + CMB_LIVE_LIVE] = BUS_LIVE[s] & LINE_LIVE[s];
      assign cmb[s*CMB_W + CMB_LIVE_DEAD] = BUS_LIVE[s] & LINE_DEAD[s];
      assign cmb[s*CMB_W + CMB_DEAD_LIVE] = BUS_DEAD[s] & LINE_LIVE[s];
      assign cmb[s*CMB_W + CMB_DEAD_DEAD] = BUS_DEAD[s] & LINE_DEAD[s];
      assign vcond_ok[s] = (U_COND[s*UCOND_W +: UCOND_W] == UC_BYPASS) |
                           (|(scer_allowed(U_COND[s*UCOND_W +: UCOND_W]) & cmb[s*CMB_W +: CMB_W]));
      assign cur[B + SIG_BLOCKED]    = BLOCKED[s];
      assign cur[B + SIG_CHECK_OK]   = CHECK_OK[s];
      assign cur[B + SIG_BYPASS]     = BYPASS[s];
      assign cur[B + SIG_VCOND_OK]   = vcond_ok[s];
      assign cur[B + SIG_VDIFF_SUM]  = VDIFF_OK[s];
      assign cur[B + SIG_ADIFF_SUM]  = angle_ok[s];
      assign cur[B + SIG_FDIFF_SUM]  = FDIFF_OK[s];
      assign cur[B + SIG_VDIFF_DET]  = VDIFF_OK[s];
      assign cur[B + SIG_ADIFF_DET]  = angle_ok[s];
      assign cur[B + SIG_FDIFF_DET]  = FDIFF_OK[s];
      assign cur[B + SIG_CMB_BASE +: CMB_W] = cmb[s*CMB_W +: CMB_W];
      assign cur[B + SIG_VBUS_HIGH]  = VBUS_HIGH[s];
      assign cur[B + SIG_VLINE_HIGH] = VLINE_HIGH[s];
      assign cur[B + SIG_FBUS_HIGH]  = FBUS_HIGH[s];
      assign cur[B + SIG_FLINE_HIGH] = FLINE_HIGH[s];
      assign cur[B + SIG_BUS_LEADS]  = BUS_LEADS[s];
      assign cur[B + SIG_LINE_LEADS] = LINE_LEADS[s];
      assign cur[B + SIG_BUS_LIVE]   = BUS_LIVE[s];
      assign cur[B + SIG_BUS_DEAD]   = BUS_DEAD[s];
      assign cur[B + SIG_LINE_LIVE]  = LINE_LIVE[s];
      assign cur[B + SIG_LINE_DEAD]  = LINE_DEAD[s];
    end
  endgenerate

  // a second change before the first leaves overwrites it: inputs are slow relay states
  assign change    = cur ^ stat_ff;
  assign capture   = change & ((cur & STORE_ON_MASK) | (~cur & STORE_OFF_MASK));
  assign found     = |pend_ff;
  assign sel       = first_set(pend_ff);
  assign grant     = found ? (NUM_SRC'(1) << sel) : '0;
  assign nxt_pend  = capture | (pend_ff & ~grant);
  assign nxt_pol   = (capture & cur) | (~capture & pol_ff);
  assign sel_stage = (sel >= SRC_W'(2 * SIG_PER_STAGE)) ? STAGE_W'(2) :
                     (sel >= SRC_W'(SIG_PER_STAGE)) ? STAGE_W'(1) : STAGE_W'(0);
  assign sel_code  = CODE_W'(sel - SRC_W'(sel_stage * SIG_PER_STAGE));
  assign sel_ts    = ts_ff[sel];
  assign pre_wrap  = pre_ff == PRE_W'(CYC_MS - 1);

  // record snapshot taken when the event leaves, not when it was seen
  assign rec_wr = {sel_ts, sel_stage, sel_code, pol_ff[sel],
                   REF1_VOLT[sel_stage*MEAS_W +: MEAS_W], REF2_VOLT[sel_stage*MEAS_W +: MEAS_W],
                   U_COND[sel_stage*UCOND_W +: UCOND_W], cmb[sel_stage*CMB_W +: CMB_W],
                   VDIFF[sel_stage*MEAS_W +: MEAS_W], VDIFF_OK[sel_stage],
                   ANGLE_DIFF[sel_stage*MEAS_W +: MEAS_W], angle_ok[sel_stage],
                   FDIFF[sel_stage*MEAS_W +: MEAS_W], FDIFF_OK[sel_stage], SETTING_GROUP};

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      pre_ff     <= '0;
      time_ms_ff <= '0;
    end else begin
      pre_ff     <= pre_wrap ? '0 : pre_ff + 1'b1;
      time_ms_ff <= time_ms_ff + TS_W'(pre_wrap);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      stat_ff <= '0;
      pend_ff <= '0;
      pol_ff  <= '0;
    end else begin
      stat_ff <= cur;
      pend_ff <= nxt_pend;
      pol_ff  <= nxt_pol;
    end
  end

  always_ff @(posedge REF_CLK) begin
    for (int i = 0; i < NUM_SRC; i++) begin
      if (capture[i]) ts_ff[i] <= time_ms_ff;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      evt_valid_ff <= 1'b0;
      evt_stage_ff <= '0;
      evt_code_ff  <= '0;
      evt_on_ff    <= 1'b0;
      evt_time_ff  <= '0;
    end else begin
      evt_valid_ff <= found;
      evt_stage_ff <= found ? sel_stage : evt_stage_ff;
      evt_code_ff  <= found ? sel_code : evt_code_ff;
      evt_on_ff    <= found ? pol_ff[sel] : evt_on_ff;
      evt_time_ff  <= found ? sel_ts : evt_time_ff;
    end
  end

  scer_log #(.DEPTH(LOG_DEPTH), .W(REC_W)) u_log (
    .clk      (REF_CLK),
    .rst_n    (RST_N),
    .wr_en    (found),
    .wr_data  (rec_wr),
    .rd_idx   (REC_SEL),
    .rd_valid (REC_VALID),
    .rd_data  (rec_q)
  );

  assign STAT_OUT  = stat_ff;
  assign EVT_VALID = evt_valid_ff;
  assign EVT_STAGE = evt_stage_ff;
  assign EVT_CODE  = evt_code_ff;
  assign EVT_ON    = evt_on_ff;
  assign EVT_TIME  = evt_time_ff;
  assign {REC_TIME, REC_STAGE, REC_CODE, REC_ON, REC_REF1, REC_REF2, REC_UCOND, REC_VSTATUS,
          REC_VDIFF, REC_VDIFF_OK, REC_ADIFF, REC_ADIFF_OK, REC_FDIFF, REC_FDIFF_OK, REC_GROUP} = rec_q;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  a_change_pends: assert property ((|capture) |=> (|pend_ff))
    else $error("stored change left nothing pending");
  a_masked_silent: assert property (capture == '0 && pend_ff == '0 |=> !EVT_VALID)
    else $error("event without stored change");
  a_stamp_kept: assert property (found |=> EVT_VALID && EVT_TIME == $past(sel_ts))
    else $error("event stamp differs from captured stamp");
  a_stage_range: assert property (EVT_VALID |-> EVT_STAGE < STAGE_W'(NUM_STAGES))
    else $error("event stage out of range");
  a_status_out: assert property (##1 STAT_OUT[SIG_BLOCKED] == $past(BLOCKED[0]))
    else $error("status output not following blocked input");
  a_code_range: assert property (EVT_VALID |-> EVT_CODE < CODE_W'(SIG_PER_STAGE))
    else $error("event code out of range");
  a_angle_limit: assert property (ANGLE_DIFF[MEAS_W-1:0] >= ANGLE_MAX_CDEG ||
    ANGLE_DIFF[MEAS_W-1:0] >= ANGLE_LIMIT[MEAS_W-1:0] && ANGLE_LIMIT[MEAS_W-1:0] >= ANGLE_MIN_CDEG
    |-> !cur[SIG_ADIFF_SUM] && !cur[SIG_ADIFF_DET])
    else $error("angle judged ok above maximum limit");
  a_ucond_default: assert property (U_COND[UCOND_W-1:0] == UC_LIVE_LIVE
    |-> cur[SIG_VCOND_OK] == (BUS_LIVE[0] & LINE_LIVE[0]))
    else $error("default voltage condition not live-live only");
  a_both_live: assert property (BUS_LIVE[0] && LINE_LIVE[0]
    |=> STAT_OUT[SIG_CMB_BASE + CMB_LIVE_LIVE])
    else $error("live-live state not reported");
  a_on_polarity: assert property (found && STORE_ON_MASK[sel] && STORE_OFF_MASK[sel] |=>
    EVT_ON == $past(stat_ff[sel]))
    else $error("event polarity wrong");

  c_two_pending: cover property ($countones(pend_ff) > 1);
  c_off_event: cover property (EVT_VALID && !EVT_ON);
  c_vcond_rise: cover property ($rose(cur[SIG_VCOND_OK]));

endmodule : scer_recorder

//--- logic/scer_pkg.sv
/*
  shared constants for the synchronism-check event recorder: widths, signal
  indices inside a stage, voltage-condition choices, angle limits, timing.
  assumes one 100 MHz system clock.
*/
package scer_pkg;

  localparam int NUM_STAGES    = 3;
  localparam int SIG_PER_STAGE = 24;
  localparam int NUM_SRC       = NUM_STAGES * SIG_PER_STAGE;
  localparam int SRC_W         = 7;
  localparam int CODE_W        = 5;
  localparam int STAGE_W       = 2;
  localparam int TS_W          = 32;
  localparam int MEAS_W        = 16;
  localparam int UCOND_W       = 4;
  localparam int CMB_W         = 4;
  localparam int GROUP_W       = 3;
  localparam int LOG_DEPTH     = 12;
  localparam int LOG_IDX_W     = 4;

  // timing: one millisecond of stamp resolution
  localparam int MS_IN_NS      = 1000000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CYC_PER_MS    = MS_IN_NS / CLK_PERIOD_NS;

  // angle limit in hundredths of a degree
  localparam logic [MEAS_W-1:0] ANGLE_MIN_CDEG = 16'h012c;
  localparam logic [MEAS_W-1:0] ANGLE_MAX_CDEG = 16'h2328;
  localparam logic [MEAS_W-1:0] ANGLE_DEF_CDEG = 16'h012c;

  // signal index inside one stage
  localparam int SIG_BLOCKED    = 0;
  localparam int SIG_CHECK_OK   = 1;
  localparam int SIG_BYPASS     = 2;
  localparam int SIG_VCOND_OK   = 3;
  localparam int SIG_VDIFF_SUM  = 4;
  localparam int SIG_ADIFF_SUM  = 5;
  localparam int SIG_FDIFF_SUM  = 6;
  localparam int SIG_VDIFF_DET  = 7;
  localparam int SIG_ADIFF_DET  = 8;
  localparam int SIG_FDIFF_DET  = 9;
  localparam int SIG_CMB_BASE   = 10;
  localparam int SIG_VBUS_HIGH  = 14;
  localparam int SIG_VLINE_HIGH = 15;
  localparam int SIG_FBUS_HIGH  = 16;
  localparam int SIG_FLINE_HIGH = 17;
  localparam int SIG_BUS_LEADS  = 18;
  localparam int SIG_LINE_LEADS = 19;
  localparam int SIG_BUS_LIVE   = 20;
  localparam int SIG_BUS_DEAD   = 21;
  localparam int SIG_LINE_LIVE  = 22;
  localparam int SIG_LINE_DEAD  = 23;

  // combined bus/line states
  localparam int CMB_LIVE_LIVE = 0;
  localparam int CMB_LIVE_DEAD = 1;
  localparam int CMB_DEAD_LIVE = 2;
  localparam int CMB_DEAD_DEAD = 3;

  typedef enum logic [UCOND_W-1:0] {
    UC_LIVE_LIVE, UC_LIVE_DEAD, UC_DEAD_LIVE,
    UC_LL_OR_LIVE_DEAD_X, UC_LIVE_LIVE_OR_DEAD_LIVE, UC_LIVE_LIVE_OR_DEAD_DEAD,
    UC_ALL_BUT_DEAD_DEAD, UC_ALL_BUT_DEAD_LIVE, UC_ALL_BUT_LIVE_DEAD, UC_BYPASS
  } scer_ucond_type;

  localparam int REC_W = TS_W + STAGE_W + CODE_W + 1 + 2 * MEAS_W + UCOND_W + CMB_W
                       + 3 * (MEAS_W + 1) + GROUP_W;

  // allowed combined states for a voltage-condition choice; bypass allows none here
  function automatic logic [CMB_W-1:0] scer_allowed(input logic [UCOND_W-1:0] c);
    logic [CMB_W-1:0] m;
    m = 4'h1;
    case (c)
      UC_LIVE_LIVE:              m = 4'h1;
      UC_LIVE_DEAD:              m = 4'h2;
      UC_DEAD_LIVE:              m = 4'h4;
      UC_LL_OR_LIVE_DEAD_X:      m = 4'h3;
      UC_LIVE_LIVE_OR_DEAD_LIVE: m = 4'h5;
      UC_LIVE_LIVE_OR_DEAD_DEAD: m = 4'h9;
      UC_ALL_BUT_DEAD_DEAD:      m = 4'h7;
      UC_ALL_BUT_DEAD_LIVE:      m = 4'hb;
      UC_ALL_BUT_LIVE_DEAD:      m = 4'hd;
      UC_BYPASS:                 m = 4'h0;
      default:                   m = 4'h1;
    endcase
    return m;
  endfunction : scer_allowed

endpackage : scer_pkg

//--- logic/scer_log.sv
/*
  twelve-deep operation record log, newest first on read, oldest overwritten.
  assumes writes and reads come from the same clock domain as the recorder.
*/
`timescale 1ns/1ps
module scer_log
  import scer_pkg::*;
#(
  parameter int DEPTH = LOG_DEPTH,
  parameter int W     = REC_W
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // write side
  input  wire logic                 wr_en,
  input  wire logic [W-1:0]         wr_data,
  // read side, index 0 is newest
  input  wire logic [LOG_IDX_W-1:0] rd_idx,
  output logic                      rd_valid,
  output logic [W-1:0]              rd_data
);

  logic [W-1:0]         mem [DEPTH];
  logic [LOG_IDX_W-1:0] wptr_ff;
  logic [LOG_IDX_W-1:0] count_ff;
  logic                 rd_valid_ff;
  logic [W-1:0]         rd_data_ff;
  logic [LOG_IDX_W-1:0] nxt_wptr;
  logic [LOG_IDX_W-1:0] nxt_count;
  logic [LOG_IDX_W:0]   back;
  logic [LOG_IDX_W-1:0] rd_addr;
  logic                 hit;

  localparam logic [LOG_IDX_W-1:0] LAST = LOG_IDX_W'(DEPTH - 1);

  // ring wrap: the oldest slot is the next one written once full
  assign nxt_wptr  = (wptr_ff == LAST) ? '0 : wptr_ff + 1'b1;
  assign nxt_count = (count_ff == LOG_IDX_W'(DEPTH)) ? count_ff : count_ff + 1'b1;
  assign back      = {1'b0, wptr_ff} + (LOG_IDX_W + 1)'(DEPTH) - 1'b1 - {1'b0, rd_idx};
  assign rd_addr   = (back >= (LOG_IDX_W + 1)'(DEPTH)) ? LOG_IDX_W'(back - (LOG_IDX_W + 1)'(DEPTH))
                                                       : back[LOG_IDX_W-1:0];
  assign hit       = rd_idx < count_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wptr_ff  <= '0;
      count_ff <= '0;
    end else if (wr_en) begin
      wptr_ff  <= nxt_wptr;
      count_ff <= nxt_count;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wptr_ff] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= '0;
    end else begin
      rd_valid_ff <= hit;
      rd_data_ff  <= hit ? mem[rd_addr] : '0;
    end
  end

  assign rd_valid = rd_valid_ff;
  assign rd_data  = rd_data_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_log_count_cap: assert property (count_ff <= LOG_IDX_W'(DEPTH))
    else $error("log count above depth");
  a_log_full_wrap: assert property (wr_en && count_ff == LOG_IDX_W'(DEPTH)
    |=> count_ff == LOG_IDX_W'(DEPTH) && wptr_ff == $past(nxt_wptr))
    else $error("full log did not overwrite oldest");
  c_log_full: cover property (wr_en && count_ff == LOG_IDX_W'(DEPTH));

endmodule : scer_log

//--- verification/scer_evt_sink.sv
/*
  event buffer stand-in: keeps every emitted event in a queue.
  assumes the recorder event outputs on the same clock.
*/
`timescale 1ns/1ps
module scer_evt_sink (
  // event stream
  input wire logic                         clk,
  input wire logic                         valid,
  input wire logic [scer_pkg::STAGE_W-1:0] stage,
  input wire logic [scer_pkg::CODE_W-1:0]  code,
  input wire logic                         on,
  input wire logic [scer_pkg::TS_W-1:0]    stamp
);
  import scer_pkg::*;
  // no stall: the real buffer takes one event per cycle too
  logic [39:0] evq [$];
  always @(posedge clk) begin
    if (valid === 1'b1) begin
      evq.push_back({stage, code, on, stamp});
    end
  end
endmodule : scer_evt_sink

//--- verification/scer_recorder_bench.sv
/*
  bench for the event recorder: drives status levels, finds events in the sink.
  assumes CYC_MS is 4, so one stamp step is four clocks.
*/
`timescale 1ns/1ps
module scer_recorder_bench;
  import scer_pkg::*;
  logic        ref_clk, rst_n, ev_v, ev_on, rv, r_on, r_aok;
  logic [2:0]  st [15];
  logic [47:0] ms [6];
  logic [11:0] ucond;
  logic [2:0]  grp, r_grp;
  logic [71:0] on_m, off_m, stat;
  logic [3:0]  sel, r_vs;
  logic [1:0]  ev_st, r_st;
  logic [4:0]  ev_c, r_c;
  logic [31:0] ev_t, r_t;
  logic [15:0] r_ad;
  int          failures, check_count;
  scer_recorder #(.CYC_MS(4)) u_dut (.REF_CLK(ref_clk), .RST_N(rst_n), .BLOCKED(st[0]), .CHECK_OK(st[1]),
    .BYPASS(st[2]), .VDIFF_OK(st[3]), .FDIFF_OK(st[4]), .VBUS_HIGH(st[5]), .VLINE_HIGH(st[6]),
    .FBUS_HIGH(st[7]), .FLINE_HIGH(st[8]), .BUS_LEADS(st[9]), .LINE_LEADS(st[10]), .BUS_LIVE(st[11]),
    .BUS_DEAD(st[12]), .LINE_LIVE(st[13]), .LINE_DEAD(st[14]), .REF1_VOLT(ms[0]), .REF2_VOLT(ms[1]),
    .VDIFF(ms[2]), .ANGLE_DIFF(ms[3]), .FDIFF(ms[4]), .ANGLE_LIMIT(ms[5]), .U_COND(ucond),
    .SETTING_GROUP(grp), .STORE_ON_MASK(on_m), .STORE_OFF_MASK(off_m), .STAT_OUT(stat), .EVT_VALID(ev_v),
    .EVT_STAGE(ev_st), .EVT_CODE(ev_c), .EVT_ON(ev_on), .EVT_TIME(ev_t), .REC_SEL(sel), .REC_VALID(rv),
    .REC_TIME(r_t), .REC_STAGE(r_st), .REC_CODE(r_c), .REC_ON(r_on), .REC_REF1(), .REC_REF2(), .REC_UCOND(),
    .REC_VSTATUS(r_vs), .REC_VDIFF(), .REC_VDIFF_OK(), .REC_ADIFF(r_ad), .REC_ADIFF_OK(r_aok), .REC_FDIFF(),
    .REC_FDIFF_OK(), .REC_GROUP(r_grp));
  scer_evt_sink u_sink (.clk(ref_clk), .valid(ev_v), .stage(ev_st), .code(ev_c), .on(ev_on), .stamp(ev_t));
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  // side events from derived states are tolerated, so search rather than pop
  function automatic logic [32:0] find(input logic [1:0] s, input logic [4:0] c, input logic o);
    foreach (u_sink.evq[i]) if (u_sink.evq[i][39:32] === {s, c, o}) return {1'b1, u_sink.evq[i][31:0]};
    return 33'h0;
  endfunction : find
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #100us;
    failures++;
    tally_and_finish();
  end
  initial begin
    logic [32:0] a, b;
    rst_n = 1'b0; foreach (st[i]) st[i] = 3'h0; foreach (ms[i]) ms[i] = 48'h0;
    ms[5] = 48'h012c_012c_012c; ucond = 12'h0; grp = 3'h5; on_m = '1; off_m = '1; sel = 4'h0;
    tick(11);
    check({stat, ev_v, rv}, 74'h0);
    @(posedge ref_clk) rst_n <= 1'b1;
    tick(150);
    u_sink.evq.delete();
    @(posedge ref_clk) st[0] <= 3'h1;
    tick(2);
    check(stat[0], 1'b1);
    repeat (38) @(posedge ref_clk);
    st[0] <= 3'h0;
    tick(40);
    a = find(2'h0, 5'h0, 1'b1);
    b = find(2'h0, 5'h0, 1'b0);
    check({a[32], b[32]}, 2'h3);
    check(b[31:0] - a[31:0], 32'ha);
    $display("test edge events done");
    u_sink.evq.delete();
    @(posedge ref_clk) off_m[25] <= 1'b0;
    st[1] <= 3'h2;
    st[11] <= 3'h5;
    st[13] <= 3'h1;
    tick(40);
    @(posedge ref_clk) st[1] <= 3'h0;
    tick(40);
    check(find(2'h1, 5'h1, 1'b1) >> 32, 1);
    check(find(2'h1, 5'h1, 1'b0) >> 32, 0);
    check(find(2'h2, 5'd20, 1'b1) >> 32, 1);
    check(find(2'h1, 5'd20, 1'b1) >> 32, 0);
    check(find(2'h0, 5'd10, 1'b1) >> 32, 1);
    check(find(2'h0, 5'h3, 1'b1) >> 32, 1);
    $display("test mask and stage done");
    u_sink.evq.delete();
    @(posedge ref_clk) ms[3][15:0] <= 16'h012c;
    tick(30);
    a = find(2'h0, 5'h5, 1'b0);
    b = find(2'h0, 5'h8, 1'b0);
    check({a[32], b[32]}, 2'h3);
    @(posedge ref_clk) ms[3][15:0] <= 16'h012b;
    tick(30);
    a = find(2'h0, 5'h5, 1'b1);
    b = find(2'h0, 5'h8, 1'b1);
    check({a[32], b[32]}, 2'h3);
    check({rv, r_st, r_c, r_on, r_ad, r_aok}, {1'b1, 2'h0, 5'h8, 1'b1, 16'h012b, 1'b1});
    check({r_vs, r_grp}, {4'h1, 3'h5});
    $display("test angle limit done");
    @(posedge ref_clk) sel <= 4'hb;
    tick(2);
    check(rv, 1'b1);
    check({r_st, r_c, r_on}, {2'h0, 5'h0, 1'b1});
    @(posedge ref_clk) sel <= 4'hc;
    tick(2);
    check({rv, r_t}, 33'h0);
    $display("test record log done");
    tally_and_finish();
  end
endmodule : scer_recorder_bench
